// >>> opmode_pkg.sv
// Constants, register map and mode encoding for the operating-mode controller.
// Assumes a single 100 MHz core clock; the crystal rate is an enable pulse.
package opmode_pkg;

    localparam int CORE_HZ = 100_000_000;
    localparam int XTAL_HZ = 32_768;
    // Longest whole count of core cycles per crystal period (rounded down)
    localparam int XTAL_DIV = CORE_HZ / XTAL_HZ;
    localparam int XTAL_CNT_W = 12;

    // Oscillator clocks from supply return to settled PLL
    localparam int PLL_SETTLE_TICKS = 4100;
    // Wake-timer units in milliseconds, then in crystal ticks
    localparam int WAKE_SHORT_MS = 2500;
    localparam int WAKE_LONG_MS = 60_000;
    localparam int WAKE_SHORT_TICKS = WAKE_SHORT_MS * XTAL_HZ / 1000;
    localparam int WAKE_LONG_TICKS = WAKE_LONG_MS * XTAL_HZ / 1000;
    localparam int UNIT_W = 21;

    // Crystal rate slot skipped in battery run (7 of 8 ticks kept)
    localparam logic [2:0] SKIP_SLOT = 3'h7;

    // Register offsets
    localparam logic [7:0] FLAG_ADDR = 8'hE8;
    localparam logic [7:0] CTRL_ADDR = 8'hE9;
    localparam logic [7:0] WAKE_ADDR = 8'hEA;
    localparam logic [7:0] STAT_ADDR = 8'hEB;

    // Flag register fields
    localparam int FLAG_LOSS = 7;
    localparam int FLAG_LOCK = 6;
    localparam int FLAG_TIMER = 5;
    localparam int FLAG_BUTTON = 4;

    // Control register fields
    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_DISP = 1;
    localparam int CTRL_CONV = 2;
    localparam int CTRL_COMP = 3;
    localparam int CTRL_DIV_LSB = 4;

    // Wake register fields
    localparam int WAKE_TIMER_PERIOD_LSB = 0;
    localparam int WAKE_TIMER_RESOLUTION = 3;
    localparam int WAKE_ARM = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [3:0] {
        MODE_FULL = 4'h1,
        MODE_BATT = 4'h2,
        MODE_DISP = 4'h4,
        MODE_SLEEP = 4'h8
    } mode_type;

endpackage : opmode_pkg

// >>> wake_timer_if.sv
// Carrier between the mode controller and its wake-up timer.
// Both ends share core_clk; no clocking here.
`timescale 1ns/1ps
interface wake_timer_if;
    logic tick;
    logic run;
    logic resolution;
    logic [2:0] period;
    logic expire;

    modport ctrl (output tick, output run, output resolution, output period, input expire);
    modport timer (input tick, input run, input resolution, input period, output expire);
endinterface : wake_timer_if

// >>> crystal_clock_gen.sv
// Crystal tick divider and processor clock enable.
// Assumes core_clk at 100 MHz and a synchronous active-high reset.
`timescale 1ns/1ps
module crystal_clock_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic full_mode,
    input wire logic batt_mode,
    input wire logic [2:0] divider,
    output logic xtal_tick,
    output logic cpu_clk_en
);

    logic [opmode_pkg::XTAL_CNT_W-1:0] xtal_cnt_reg;
    logic [2:0] eighth_reg;
    logic [7:0] fast_cnt_reg;
    logic [7:0] mask;

    assign mask = (8'h01 << divider) - 8'h01;

    always_ff @(posedge core_clk) begin
        if (rst || xtal_cnt_reg == opmode_pkg::XTAL_CNT_W'(opmode_pkg::XTAL_DIV - 1)) begin
            xtal_cnt_reg <= '0;
        end else begin
            xtal_cnt_reg <= xtal_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xtal_tick <= 1'b0;
        end else begin
            xtal_tick <= xtal_cnt_reg == opmode_pkg::XTAL_CNT_W'(opmode_pkg::XTAL_DIV - 1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            eighth_reg <= 3'h0;
        end else if (xtal_tick) begin
            eighth_reg <= eighth_reg + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !full_mode) begin
            fast_cnt_reg <= 8'h00;
        end else begin
            fast_cnt_reg <= fast_cnt_reg + 8'h01;
        end
    end

    // R10 clock source select
    // R11 divider ignored in battery run
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_clk_en <= 1'b0;
        end else if (full_mode) begin
            cpu_clk_en <= (fast_cnt_reg & mask) == mask;
        end else if (batt_mode) begin
            cpu_clk_en <= xtal_tick && eighth_reg != opmode_pkg::SKIP_SLOT;
        end else begin
            cpu_clk_en <= 1'b0;
        end
    end

endmodule : crystal_clock_gen

// >>> wake_timer.sv
// Wake-up timer counting crystal ticks in units of 2.5 s or 1 min.
// Assumes run stays high from low-power entry until wake.
`timescale 1ns/1ps
module wake_timer #(
    parameter int SHORT_TICKS = opmode_pkg::WAKE_SHORT_TICKS,
    parameter int LONG_TICKS = opmode_pkg::WAKE_LONG_TICKS
) (
    input wire logic core_clk,
    input wire logic rst,
    wake_timer_if.timer wt
);

    logic [opmode_pkg::UNIT_W-1:0] unit_cnt_reg;
    logic [opmode_pkg::UNIT_W-1:0] unit_last;
    logic [2:0] units_reg;
    logic [2:0] target;
    logic done_reg;

    assign unit_last = wt.resolution ? opmode_pkg::UNIT_W'(LONG_TICKS - 1)
                                     : opmode_pkg::UNIT_W'(SHORT_TICKS - 1);
    // Period of zero behaves as one unit
    assign target = (wt.period == 3'h0) ? 3'h1 : wt.period;

    // R20 unit and period count
    always_ff @(posedge core_clk) begin
        if (rst || !wt.run) begin
            unit_cnt_reg <= '0;
            units_reg <= 3'h0;
        end else if (wt.tick && !done_reg) begin
            if (unit_cnt_reg == unit_last) begin
                unit_cnt_reg <= '0;
                units_reg <= units_reg + 3'h1;
            end else begin
                unit_cnt_reg <= unit_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !wt.run) begin
            done_reg <= 1'b0;
            wt.expire <= 1'b0;
        end else begin
            wt.expire <= !done_reg && units_reg == target;
            if (units_reg == target) begin
                done_reg <= 1'b1;
            end
        end
    end

endmodule : wake_timer

// >>> operating_mode_controller.sv
// Operating-mode controller: full power plus three battery modes.
// Assumes pin inputs asynchronous to core_clk and a one-cycle register port.
// Overview of operation
// R01 - Full power only while supply present and PLL stable.
// R02 - Supply loss or battery wake with margin enters battery run.
// R03 - From battery run, display or sleep request forces that mode, processor off.
// R04 - Leaving full power sets the PLL-loss flag, bit 7.
// R05 - Returning to full power on PLL lock sets the PLL-lock flag, bit 6.
// R06 - Display or sleep return to battery run only on timer or button.
// R07 - Button high sets bit 4; timer timeout sets bit 5.
// R08 - Without supply, margin loss enters sleep and stays there.
// R09 - Supply return leaves any battery mode for full power once settled.
// R10 - Battery run clocks processor at 7/8 crystal; full power from PLL.
// R11 - Processor divider kept across battery run but ignored there.
// R12 - PLL not locked forces converter and compute enables to zero.
// R13 - PLL lock fall clears compute program counter and halts filtering.
// R14 - Compute, filter, analog, divider, optical, flash write only in full power.
// R15 - Battery run keeps debug, pins, watchdog, display, serial, memories alive.
// R16 - Display mode: processor off, segments kept, two pins may blink.
// R17 - Display mode left only on power-up, timer or button; the code also leaves it for sleep on margin loss.
// R18 - Firmware must move battery run into sleep itself.
// R19 - After supply return, processor held in reset until settle count elapses.
// R20 - Wake unit 1 min or 2.5 s, period one to seven units.
// R21 - One-hot mode register; full-power entry beats a coincident wake.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module operating_mode_controller #(
    parameter int SETTLE_TICKS = opmode_pkg::PLL_SETTLE_TICKS,
    parameter int SHORT_TICKS = opmode_pkg::WAKE_SHORT_TICKS,
    parameter int LONG_TICKS = opmode_pkg::WAKE_LONG_TICKS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic supply_sense_input,
    input wire logic pll_locked,
    input wire logic battery_margin_good,
    input wire logic push_button_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [3:0] mode_state,
    output logic cpu_reset,
    output logic cpu_clk_en,
    output logic converter_enable,
    output logic compute_enable,
    output logic compute_pc_clear,
    output logic filter_run,
    output logic full_power_en,
    output logic battery_run_en,
    output logic eeprom_slow,
    output logic display_en,
    output logic blink_en
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 3 supply, 2 lock, 1 margin, 0 button
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic supply_s;
    logic lock_s;
    logic bat_s;
    logic button_s;
    logic button_prev_reg;
    logic button_rise;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {supply_sense_input, pll_locked, battery_margin_good, push_button_pin};
            sync2_reg <= sync1_reg;
        end
    end

    assign supply_s = sync2_reg[3];
    assign lock_s = sync2_reg[2];
    assign bat_s = sync2_reg[1];
    assign button_s = sync2_reg[0];
    assign button_rise = button_s && !button_prev_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            button_prev_reg <= 1'b0;
        end else begin
            button_prev_reg <= button_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clocks and wake timer
    wake_timer_if wt ();
    logic xtal_tick;
    opmode_pkg::mode_type mode_reg;
    opmode_pkg::mode_type mode_next;
    logic [7:0] ctrl_reg;
    logic [7:0] wake_reg;
    logic [7:0] flag_reg;

    crystal_clock_gen u_clk (
        .core_clk(core_clk),
        .rst(rst),
        .full_mode(mode_reg == opmode_pkg::MODE_FULL),
        .batt_mode(mode_reg == opmode_pkg::MODE_BATT),
        .divider(ctrl_reg[opmode_pkg::CTRL_DIV_LSB +: 3]),
        .xtal_tick(xtal_tick),
        .cpu_clk_en(cpu_clk_en)
    );

    assign wt.tick = xtal_tick;
    assign wt.resolution = wake_reg[opmode_pkg::WAKE_TIMER_RESOLUTION];
    assign wt.period = wake_reg[opmode_pkg::WAKE_TIMER_PERIOD_LSB +: 3];
    // Timer runs only while armed in display or sleep, so it restarts on every entry from full power or battery run
    assign wt.run = wake_reg[opmode_pkg::WAKE_ARM]
        && (mode_reg == opmode_pkg::MODE_DISP || mode_reg == opmode_pkg::MODE_SLEEP);

    wake_timer #(
        .SHORT_TICKS(SHORT_TICKS),
        .LONG_TICKS(LONG_TICKS)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .wt(wt.timer)
    );

    ////////////////////////////////////////////////////////////////////////
    // PLL settle tracking
    logic [31:0] settle_cnt_reg;
    logic pll_ok_reg;
    logic pll_ok_prev_reg;

    // R19 settle count after supply return
    always_ff @(posedge core_clk) begin
        if (rst || !supply_s) begin
            settle_cnt_reg <= 32'h0;
        end else if (xtal_tick && settle_cnt_reg != 32'(SETTLE_TICKS)) begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pll_ok_reg <= 1'b0;
            pll_ok_prev_reg <= 1'b0;
        end else begin
            pll_ok_reg <= supply_s && lock_s && settle_cnt_reg == 32'(SETTLE_TICKS);
            pll_ok_prev_reg <= pll_ok_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode machine
    logic sleep_req;
    logic disp_req;
    logic wake_ev;
    logic margin_lost;

    assign sleep_req = reg_wr && reg_addr == opmode_pkg::CTRL_ADDR && reg_wdata[opmode_pkg::CTRL_SLEEP];
    assign disp_req = reg_wr && reg_addr == opmode_pkg::CTRL_ADDR && reg_wdata[opmode_pkg::CTRL_DISP];
    assign wake_ev = wt.expire || button_rise;
    assign margin_lost = !supply_s && !bat_s;

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            // R01 leave full power when PLL drops
            opmode_pkg::MODE_FULL: begin
                if (!pll_ok_reg) begin
                    mode_next = bat_s ? opmode_pkg::MODE_BATT : opmode_pkg::MODE_SLEEP;
                end
            end
            // R03 one request wins, sleep first
            opmode_pkg::MODE_BATT: begin
                if (pll_ok_reg) begin
                    mode_next = opmode_pkg::MODE_FULL;
                end else if (margin_lost || sleep_req) begin
                    mode_next = opmode_pkg::MODE_SLEEP;
                end else if (disp_req) begin
                    mode_next = opmode_pkg::MODE_DISP;
                end
            end
            // R17 only power, margin loss, timer or button
            opmode_pkg::MODE_DISP: begin
                if (pll_ok_reg) begin
                    mode_next = opmode_pkg::MODE_FULL;
                end else if (margin_lost) begin
                    mode_next = opmode_pkg::MODE_SLEEP;
                end else if (wake_ev) begin
                    mode_next = opmode_pkg::MODE_BATT;
                end
            end
            // R08 wake from sleep needs margin
            // R06 timer or button wake only
            // R09 supply return enters full power
            opmode_pkg::MODE_SLEEP: begin
                if (pll_ok_reg) begin
                    mode_next = opmode_pkg::MODE_FULL;
                end else if (wake_ev && bat_s) begin
                    mode_next = opmode_pkg::MODE_BATT;
                end
            end
            default: begin
                mode_next = opmode_pkg::MODE_SLEEP;
            end
        endcase
    end

    // R21 single one-hot state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= opmode_pkg::MODE_SLEEP;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: write one to clear, a set in the same cycle wins
    logic [7:0] flag_set;
    logic [7:0] flag_clr;

    always_comb begin
        flag_set = 8'h00;
        // R04 loss on leaving full power
        flag_set[opmode_pkg::FLAG_LOSS] = mode_reg == opmode_pkg::MODE_FULL
            && mode_next != opmode_pkg::MODE_FULL;
        // R05 lock on entering full power
        flag_set[opmode_pkg::FLAG_LOCK] = mode_reg != opmode_pkg::MODE_FULL
            && mode_next == opmode_pkg::MODE_FULL;
        // R07 timer and button flags
        flag_set[opmode_pkg::FLAG_TIMER] = wt.expire;
        flag_set[opmode_pkg::FLAG_BUTTON] = button_s;
    end

    assign flag_clr = (reg_wr && reg_addr == opmode_pkg::FLAG_ADDR) ? reg_wdata : 8'h00;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_reg <= opmode_pkg::RESET_BYTE;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr & 8'hF0) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and wake configuration
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= opmode_pkg::RESET_BYTE;
        end else begin
            if (reg_wr && reg_addr == opmode_pkg::CTRL_ADDR) begin
                ctrl_reg <= reg_wdata & 8'h7C;
            end
            // R12 enables held at zero without lock
            if (!pll_ok_reg) begin
                ctrl_reg[opmode_pkg::CTRL_CONV] <= 1'b0;
                ctrl_reg[opmode_pkg::CTRL_COMP] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_reg <= opmode_pkg::RESET_BYTE;
        end else if (reg_wr && reg_addr == opmode_pkg::WAKE_ADDR) begin
            wake_reg <= reg_wdata & 8'h1F;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                opmode_pkg::FLAG_ADDR: reg_rdata <= flag_reg;
                opmode_pkg::CTRL_ADDR: reg_rdata <= ctrl_reg;
                opmode_pkg::WAKE_ADDR: reg_rdata <= wake_reg;
                opmode_pkg::STAT_ADDR: reg_rdata <= {1'b0, supply_s, bat_s, pll_ok_reg, mode_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Function gating outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_state <= 4'h0;
            cpu_reset <= 1'b1;
            converter_enable <= 1'b0;
            compute_enable <= 1'b0;
            compute_pc_clear <= 1'b0;
            filter_run <= 1'b0;
            full_power_en <= 1'b0;
            battery_run_en <= 1'b0;
            eeprom_slow <= 1'b0;
            display_en <= 1'b0;
            blink_en <= 1'b0;
        end else begin
            mode_state <= mode_reg;
            // R19 reset held while settling
            // R16 processor off in low power
            cpu_reset <= (mode_reg == opmode_pkg::MODE_DISP) || (mode_reg == opmode_pkg::MODE_SLEEP)
                || (supply_s && !pll_ok_reg);
            converter_enable <= ctrl_reg[opmode_pkg::CTRL_CONV] && pll_ok_reg;
            compute_enable <= ctrl_reg[opmode_pkg::CTRL_COMP] && pll_ok_reg;
            // R13 program counter clear on lock fall
            compute_pc_clear <= pll_ok_prev_reg && !pll_ok_reg;
            // R14 full power only functions
            full_power_en <= mode_reg == opmode_pkg::MODE_FULL;
            filter_run <= mode_reg == opmode_pkg::MODE_FULL && pll_ok_reg
                && ctrl_reg[opmode_pkg::CTRL_COMP];
            // R15 battery run keeps peripherals
            battery_run_en <= mode_reg == opmode_pkg::MODE_FULL || mode_reg == opmode_pkg::MODE_BATT;
            eeprom_slow <= mode_reg == opmode_pkg::MODE_BATT;
            display_en <= mode_reg != opmode_pkg::MODE_SLEEP;
            blink_en <= mode_reg == opmode_pkg::MODE_DISP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_full_needs_pll;
        !pll_ok_reg && mode_reg == opmode_pkg::MODE_FULL |=> mode_reg != opmode_pkg::MODE_FULL;
    endproperty
    a_full_needs_pll: assert property (p_full_needs_pll) else $error("full power kept without PLL"); // R01

    property p_loss_to_batt;
        mode_reg == opmode_pkg::MODE_FULL && !pll_ok_reg && bat_s |=> mode_reg == opmode_pkg::MODE_BATT;
    endproperty
    a_loss_to_batt: assert property (p_loss_to_batt) else $error("supply loss missed battery run"); // R02

    property p_disp_req;
        mode_reg == opmode_pkg::MODE_BATT && disp_req && !sleep_req && !pll_ok_reg && !margin_lost
            |=> mode_reg == opmode_pkg::MODE_DISP ##1 cpu_reset;
    endproperty
    a_disp_req: assert property (p_disp_req) else $error("display request not taken"); // R03

    property p_loss_flag;
        mode_reg == opmode_pkg::MODE_FULL && !pll_ok_reg |=> flag_reg[opmode_pkg::FLAG_LOSS];
    endproperty
    a_loss_flag: assert property (p_loss_flag) else $error("loss flag not set"); // R04

    property p_lock_entry;
        mode_reg != opmode_pkg::MODE_FULL && pll_ok_reg
            |=> mode_reg == opmode_pkg::MODE_FULL && flag_reg[opmode_pkg::FLAG_LOCK];
    endproperty
    a_lock_entry: assert property (p_lock_entry) else $error("full power entry or lock flag missing"); // R05

    property p_disp_stays;
        mode_reg == opmode_pkg::MODE_DISP && !wake_ev && !pll_ok_reg && !margin_lost
            |=> mode_reg == opmode_pkg::MODE_DISP;
    endproperty
    a_disp_stays: assert property (p_disp_stays) else $error("display mode left without cause"); // R17

    property p_button_flag;
        button_s |=> flag_reg[opmode_pkg::FLAG_BUTTON];
    endproperty
    a_button_flag: assert property (p_button_flag) else $error("button flag not set"); // R07

    property p_sleep_sticky;
        mode_reg == opmode_pkg::MODE_SLEEP && !pll_ok_reg && !(wake_ev && bat_s)
            |=> mode_reg == opmode_pkg::MODE_SLEEP;
    endproperty
    a_sleep_sticky: assert property (p_sleep_sticky) else $error("sleep left without cause"); // R08

    property p_enables_forced;
        !pll_ok_reg |=> !converter_enable && !compute_enable;
    endproperty
    a_enables_forced: assert property (p_enables_forced) else $error("enables high without lock"); // R12

    property p_pc_clear;
        $fell(pll_ok_reg) |=> compute_pc_clear ##1 !filter_run;
    endproperty
    a_pc_clear: assert property (p_pc_clear) else $error("no program counter clear"); // R13

    c_enter_disp: cover property (mode_reg == opmode_pkg::MODE_BATT ##1 mode_reg == opmode_pkg::MODE_DISP);
    c_timer_wake: cover property (wt.expire ##1 mode_reg == opmode_pkg::MODE_BATT);
    c_full_return: cover property (mode_reg == opmode_pkg::MODE_BATT ##1 mode_reg == opmode_pkg::MODE_FULL);

endmodule : operating_mode_controller

// >>> testbench.sv
// Self-checking bench for the operating-mode controller.
// Assumes shortened settle and wake-unit counts; crystal tick stays 3051 cycles.
`timescale 1ns/1ps
module testbench;
logic core_clk = 1'b0, rst = 1'b1, supply_sense_input = 1'b0, pll_locked = 1'b0;
logic battery_margin_good = 1'b1, push_button_pin = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
logic [3:0] mode_state;
logic cpu_reset, cpu_clk_en, converter_enable, compute_enable, compute_pc_clear, filter_run;
logic full_power_en, battery_run_en, eeprom_slow, display_en, blink_en;
int miscompares = 0, n_tests = 0;
always #5 core_clk = ~core_clk;
operating_mode_controller #(.SETTLE_TICKS(4), .SHORT_TICKS(3), .LONG_TICKS(5)) i_operating_mode_controller (
    .core_clk, .rst, .supply_sense_input, .pll_locked, .battery_margin_good, .push_button_pin,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_state, .cpu_reset, .cpu_clk_en,
    .converter_enable, .compute_enable, .compute_pc_clear, .filter_run, .full_power_en,
    .battery_run_en, .eeprom_slow, .display_en, .blink_en);
////////////////////////////////////////////////////////////////
task end_of_test;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask : end_of_test
task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
        miscompares++;
        $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask : chk
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
endtask : wr
// Data stands only in the cycle after the strobe
task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
endtask : rd
// Bounded so a stuck mode ends the run
task wait_mode(input logic [3:0] m);
    for (int i = 0; i < 40000 && mode_state !== m; i++) @(posedge core_clk);
    #1 chk({4'h0, mode_state}, {4'h0, m});
    if (mode_state !== m) end_of_test();
endtask : wait_mode
////////////////////////////////////////////////////////////////
task t_power_up;
    rd(8'h00);
    chk(rd_val, 8'h00);
    chk({4'h0, mode_state}, 8'h08);
    supply_sense_input <= 1'b1; pll_locked <= 1'b1;
    repeat (100) @(posedge core_clk);
    #1 chk({7'h0, cpu_reset}, 8'h01);
    wait_mode(4'h1);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h0, cpu_reset}, 8'h00);
    chk({7'h0, full_power_en}, 8'h01);
    wr(8'hE9, 8'h0C);
    repeat (3) @(posedge core_clk);
    #1 chk({6'h0, converter_enable, compute_enable}, 8'h03);
    chk({7'h0, cpu_clk_en}, 8'h01);
    $display("test power_up done");
endtask : t_power_up
task t_brownout;
    supply_sense_input <= 1'b0;
    for (int i = 0; i < 10 && compute_pc_clear !== 1'b1; i++) begin
        @(posedge core_clk);
        #1;
    end
    chk({7'h0, compute_pc_clear}, 8'h01);
    wait_mode(4'h2);
    repeat (2) @(posedge core_clk);
    #1 chk({5'h0, converter_enable, compute_enable, filter_run}, 8'h00);
    chk({5'h0, battery_run_en, eeprom_slow, full_power_en}, 8'h06);
    rd(8'hE8);
    chk({7'h0, rd_val[7]}, 8'h01);
    wr(8'hE8, 8'hF0);
    rd(8'hE8);
    chk(rd_val, 8'h00);
    $display("test brownout done");
endtask : t_brownout
task t_sleep_wake;
    // firmware moves battery run to sleep
    wr(8'hE9, 8'h01);
    wait_mode(4'h8);
    repeat (500) @(posedge core_clk);
    #1 chk({4'h0, mode_state}, 8'h08);
    push_button_pin <= 1'b1;
    wait_mode(4'h2);
    rd(8'hE8);
    chk({7'h0, rd_val[4]}, 8'h01);
    push_button_pin <= 1'b0;
    wr(8'hEA, 8'h11);
    wr(8'hE9, 8'h02);
    wait_mode(4'h4);
    repeat (2) @(posedge core_clk);
    #1 chk({5'h0, battery_run_en, display_en, blink_en}, 8'h03);
    repeat (2000) @(posedge core_clk);
    #1 chk({4'h0, mode_state}, 8'h04);
    wait_mode(4'h2);
    rd(8'hE8);
    chk({7'h0, rd_val[5]}, 8'h01);
    wr(8'hE9, 8'h03);
    wait_mode(4'h8);
    wait_mode(4'h2);
    wr(8'hEA, 8'h00);
    $display("test sleep_wake done");
endtask : t_sleep_wake
task t_margin;
    supply_sense_input <= 1'b1;
    wait_mode(4'h1);
    rd(8'hE8);
    chk({7'h0, rd_val[6]}, 8'h01);
    supply_sense_input <= 1'b0; battery_margin_good <= 1'b0;
    wait_mode(4'h8);
    battery_margin_good <= 1'b1;
    repeat (12000) @(posedge core_clk);
    #1 chk({4'h0, mode_state}, 8'h08);
    supply_sense_input <= 1'b1;
    wait_mode(4'h1);
    $display("test margin done");
endtask : t_margin
initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_power_up();
    t_brownout();
    t_sleep_wake();
    t_margin();
    end_of_test();
end
endmodule : testbench
